// File: logic/mpetc_pkg.sv
// Purpose: Constants for the label push and TC remark block
// Assumes: 32-bit APB register access, byte-wide frame stream
// Notes: Entry bit positions follow the encapsulation entry layout
package mpetc_pkg;

  // Encapsulation entry layout
  localparam int PUSH_BITS = 272;
  localparam int PUSH_LSB = 0;
  localparam int SEL0_POS = 272;
  localparam int MAP0_POS = 275;
  localparam int SEL1_POS = 276;
  localparam int MAP1_POS = 279;
  localparam int TAGGED_POS = 294;
  localparam int SEL_W = 3;
  localparam int ENTRY_WORDS = 10;
  localparam int ENTRY_BITS = 320;

  // Absolute TC bit positions of label 0 and label 1 inside the push data
  localparam int L0_TC_LSB_TAGGED = 105;
  localparam int L0_TC_LSB_UNTAGGED = 137;
  localparam int L1_TC_LSB_TAGGED = 73;
  localparam int L1_TC_LSB_UNTAGGED = 105;

  // Push limits and table sizes
  localparam logic [5:0] MAX_PUSH_BYTES = 6'd34;
  localparam int ENTRIES = 16;
  localparam int QMAP_TABLES = 32;

  // Stream widths
  localparam int BYTE_W = 8;
  localparam int FIFO_W = 10;
  localparam int FIFO_D = 8;

  // APB map (byte addresses)
  localparam logic [11:0] ENCAP_BASE = 12'h000;
  localparam logic [11:0] QMAP_BASE = 12'h400;
  localparam logic [11:0] CTRL_ADDR = 12'h480;
  localparam logic [11:0] STATUS_ADDR = 12'h484;
  localparam logic [11:0] FRAMES_ADDR = 12'h488;

  // Reset values
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    MPETC_IDLE = 2'b00,
    MPETC_PUSH = 2'b01,
    MPETC_PASS = 2'b10
  } mpetc_state_t;

endpackage

// File: logic/mpetc_top.sv
// Purpose: Prepend an encapsulation header and label stack, remark label TC bits
// Assumes: Stream and metadata come from logic on pclk; APB slave on pclk
// Notes: One design file holding the output FIFO and the rewriter
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps

module mpetc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [CW-1:0] count_r, count_nxt;
  logic do_wr, do_rd;

  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_valid & rd_ready;
  assign rd_data = mem[rd_ptr_r];
  assign count_nxt = count_r + CW'(do_wr) - CW'(do_rd);

  always_ff @(posedge clk) begin
    if (ce && do_wr) begin
      mem[wr_ptr_r] <= wr_data;
    end
  end

  // Flags are flops so the ports carry no decode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      rd_valid <= 1'b0;
      wr_ready <= 1'b1;
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
      rd_valid <= (count_nxt != '0);
      wr_ready <= (count_nxt != DEPTH_C);
    end
  end
endmodule

module mpetc_top
  import mpetc_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ingress frame stream
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic in_eop,
  // Per-frame metadata, valid with the first byte
  input wire logic [5:0] push_byte_count,
  input wire logic [3:0] encap_table_index,
  input wire logic [2:0] qos_class,
  input wire logic [1:0] drop_precedence,
  input wire logic [2:0] classified_tc,
  // Egress frame stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_sop,
  output logic out_eop
);

  // Register storage
  logic [31:0] encap_mem [ENTRIES*16];
  logic [23:0] qmap_r [QMAP_TABLES];
  logic push_enable_r;
  logic [31:0] frames_pushed_r;

  // Input holding stage
  logic hold_v_r, hold_v_nxt;
  logic [7:0] hold_data_r;
  logic hold_sop_r, hold_eop_r;
  logic [5:0] hold_cnt_r;
  logic [3:0] hold_idx_r;
  logic [2:0] hold_qos_r, hold_ctc_r;
  logic [1:0] hold_dp_r;
  logic take, consume;

  // Rewriter state
  mpetc_state_t state_r;
  logic [PUSH_BITS-1:0] push_sr_r, remarked;
  logic [5:0] push_left_r, push_len;
  logic first_r, push_ok;
  logic [ENTRY_BITS-1:0] entry;

  // FIFO fill side
  logic f_wr_valid, f_wr_ready;
  logic [FIFO_W-1:0] f_wr_data;

  // APB decode
  logic apb_acc, apb_wr, in_encap, in_qmap, addr_ok;
  logic [31:0] rd_word;

  function automatic logic [2:0] remark_tc(
    input logic remap_en,
    input logic [2:0] sel,
    input logic [23:0] table_row,
    input logic [2:0] qos, ctc, orig
  );
    logic [4:0] bitpos;
    bitpos = {1'b0, qos, 1'b0} + {2'b00, qos};
    if (remap_en) begin
      remark_tc = table_row[bitpos +: 3];
    end else if (sel[0]) begin
      remark_tc = ctc;
    end else begin
      remark_tc = orig;
    end
  endfunction

  // Entry assembly from the selected index
  always_comb begin
    for (int w = 0; w < ENTRY_WORDS; w++) begin
      entry[32*w +: 32] = encap_mem[{hold_idx_r, 4'(w)}];
    end
  end

  // TC remark applied to the push image before any byte is emitted
  always_comb begin
    logic [2:0] sel0, sel1;
    int l0, l1;
    sel0 = entry[SEL0_POS +: SEL_W];
    sel1 = entry[SEL1_POS +: SEL_W];
    remarked = entry[PUSH_LSB +: PUSH_BITS];
    l0 = entry[TAGGED_POS] ? L0_TC_LSB_TAGGED : L0_TC_LSB_UNTAGGED;
    l1 = entry[TAGGED_POS] ? L1_TC_LSB_TAGGED : L1_TC_LSB_UNTAGGED;
    remarked[l0 +: 3] = remark_tc(entry[MAP0_POS], sel0, qmap_r[{sel0, hold_dp_r}],
                                  hold_qos_r, hold_ctc_r, remarked[l0 +: 3]);
    remarked[l1 +: 3] = remark_tc(entry[MAP1_POS], sel1, qmap_r[{sel1, hold_dp_r}],
                                  hold_qos_r, hold_ctc_r, remarked[l1 +: 3]);
  end

  assign push_ok = push_enable_r && (hold_cnt_r != 6'd0) && (hold_idx_r != 4'd0);
  assign push_len = (hold_cnt_r > MAX_PUSH_BYTES) ? MAX_PUSH_BYTES : hold_cnt_r;

  // Rewriter datapath into the FIFO
  always_comb begin
    f_wr_valid = 1'b0;
    f_wr_data = '0;
    consume = 1'b0;
    unique case (state_r)
      MPETC_IDLE: begin
        consume = hold_v_r && !hold_sop_r;
      end
      MPETC_PUSH: begin
        f_wr_valid = 1'b1;
        f_wr_data = {first_r, 1'b0, push_sr_r[PUSH_BITS-1 -: BYTE_W]};
      end
      MPETC_PASS: begin
        f_wr_valid = hold_v_r;
        f_wr_data = {first_r, hold_eop_r, hold_data_r};
        consume = hold_v_r && f_wr_ready;
      end
      default: begin
        f_wr_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= MPETC_IDLE;
      push_sr_r <= '0;
      push_left_r <= 6'd0;
      first_r <= 1'b0;
      frames_pushed_r <= ZERO_WORD;
    end else if (ce) begin
      unique case (state_r)
        MPETC_IDLE: begin
          if (hold_v_r && hold_sop_r) begin
            first_r <= 1'b1;
            if (push_ok) begin
              push_sr_r <= remarked;
              push_left_r <= push_len;
              state_r <= MPETC_PUSH;
              frames_pushed_r <= frames_pushed_r + 1'b1;
            end else begin
              state_r <= MPETC_PASS;
            end
          end
        end
        MPETC_PUSH: begin
          if (f_wr_ready) begin
            push_sr_r <= {push_sr_r[PUSH_BITS-BYTE_W-1:0], 8'h00};
            push_left_r <= push_left_r - 1'b1;
            first_r <= 1'b0;
            if (push_left_r == 6'd1) begin
              state_r <= MPETC_PASS;
            end
          end
        end
        MPETC_PASS: begin
          if (consume) begin
            first_r <= 1'b0;
            if (hold_eop_r) begin
              state_r <= MPETC_IDLE;
            end
          end
        end
        default: begin
          state_r <= MPETC_IDLE;
        end
      endcase
    end
  end

  // Holding stage: costs a bubble per byte but keeps in_ready a flop
  assign take = in_valid && in_ready;
  assign hold_v_nxt = take || (hold_v_r && !consume);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_v_r <= 1'b0;
      in_ready <= 1'b0;
      hold_data_r <= 8'h00;
      hold_sop_r <= 1'b0;
      hold_eop_r <= 1'b0;
      hold_cnt_r <= 6'd0;
      hold_idx_r <= 4'd0;
      hold_qos_r <= 3'd0;
      hold_dp_r <= 2'd0;
      hold_ctc_r <= 3'd0;
    end else if (ce) begin
      hold_v_r <= hold_v_nxt;
      in_ready <= !hold_v_nxt;
      if (take) begin
        hold_data_r <= in_data;
        hold_sop_r <= in_sop;
        hold_eop_r <= in_eop;
        if (in_sop) begin
          hold_cnt_r <= push_byte_count;
          hold_idx_r <= encap_table_index;
          hold_qos_r <= qos_class;
          hold_dp_r <= drop_precedence;
          hold_ctc_r <= classified_tc;
        end
      end
    end
  end

  mpetc_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .wr_valid(f_wr_valid),
    .wr_data(f_wr_data),
    .wr_ready(f_wr_ready),
    .rd_valid(out_valid),
    .rd_data({out_sop, out_eop, out_data}),
    .rd_ready(out_ready)
  );

  // APB decode: one wait state, access completes on the second penable cycle
  assign apb_acc = psel && penable && pready;
  assign apb_wr = apb_acc && pwrite;
  assign in_encap = (paddr < QMAP_BASE) && (paddr[5:2] < 4'(ENTRY_WORDS)) && (paddr[1:0] == 2'b00);
  assign in_qmap = (paddr >= QMAP_BASE) && (paddr < CTRL_ADDR) && (paddr[1:0] == 2'b00);
  assign addr_ok = in_encap || in_qmap || (paddr == CTRL_ADDR) ||
                   (paddr == STATUS_ADDR) || (paddr == FRAMES_ADDR);

  always_comb begin
    rd_word = ZERO_WORD;
    if (in_encap) begin
      rd_word = encap_mem[paddr[9:2]];
    end else if (in_qmap) begin
      rd_word = {8'h00, qmap_r[paddr[6:2]]};
    end else if (paddr == CTRL_ADDR) begin
      rd_word = {31'd0, push_enable_r};
    end else if (paddr == STATUS_ADDR) begin
      rd_word = {27'd0, out_valid, hold_v_r, f_wr_ready, state_r};
    end else if (paddr == FRAMES_ADDR) begin
      rd_word = frames_pushed_r;
    end
  end

  // Encap entry contents carry no reset; software loads them before use
  always_ff @(posedge pclk) begin
    if (ce && apb_wr && in_encap) begin
      encap_mem[paddr[9:2]] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < QMAP_TABLES; t++) begin
        qmap_r[t] <= 24'h00_0000;
      end
      push_enable_r <= CTRL_RESET;
    end else if (ce && apb_wr) begin
      if (in_qmap) begin
        qmap_r[paddr[6:2]] <= pwdata[23:0];
      end else if (paddr == CTRL_ADDR) begin
        push_enable_r <= pwdata[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= ZERO_WORD;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_word : ZERO_WORD;
      pslverr <= psel && penable && !pready && !addr_ok;
    end
  end

endmodule

// File: dv/mpetc_chk.sv
// Purpose: Port-level checks of the push and remark block
// Assumes: ce held high by the bench
// Notes: Pass check relies on frames leaving one at a time
`timescale 1ns/100ps
module mpetc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_sop,
  input wire logic [5:0] push_byte_count,
  input wire logic [3:0] encap_table_index,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_sop,
  input wire logic out_eop
);
  logic pass_r;
  logic [7:0] first_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence
  // First byte of a frame with zero push count or zero index must lead the output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_r <= 1'b0;
      first_r <= 8'h00;
    end else if (in_valid && in_ready && in_sop) begin
      pass_r <= (push_byte_count == 6'h00) || (encap_table_index == 4'h0);
      first_r <= in_data;
    end
  end
  a_apb_wait: assert property (s_setup |=> !pready) else $error("pready too early");
  a_apb_slot: assert property (s_setup ##1 s_access |=> pready) else $error("pready missing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_qual: assert property (pready |-> psel && penable) else $error("pready unasked");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_err_paired: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_head_hold: assert property (out_valid && !out_ready && ce |=> out_valid &&
    $stable(out_data) && $stable({out_sop, out_eop})) else $error("head changed");
  a_in_bubble: assert property (in_valid && in_ready |=> !in_ready) else $error("no bubble");
  a_pass_first: assert property (out_valid && out_sop && pass_r |-> out_data == first_r)
    else $error("unpushed frame altered");
endmodule
bind mpetc_top mpetc_chk u_mpetc_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
  .push_byte_count(push_byte_count), .encap_table_index(encap_table_index),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop),
  .out_eop(out_eop));

// File: dv/mpetc_src.sv
// Purpose: Lookup and classifier stand-in feeding the ingress stream
// Assumes: A byte is taken at an edge with in_ready high
// Notes: Idle data shows the inverse of the last byte
`timescale 1ns/100ps
module mpetc_src (
  // Clock
  input wire logic pclk,
  // Stream
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sop,
  output logic in_eop,
  // Metadata
  output logic [5:0] push_byte_count,
  output logic [3:0] encap_table_index,
  output logic [2:0] qos_class,
  output logic [1:0] drop_precedence,
  output logic [2:0] classified_tc
);
  initial {in_valid, in_data, in_sop, in_eop} = 11'h000;
  initial {push_byte_count, encap_table_index, qos_class, drop_precedence, classified_tc} = 18'h0;
  task automatic send(input logic [7:0] fb[$], input logic [5:0] c, input logic [3:0] ix,
    input logic [2:0] q, input logic [1:0] d, input logic [2:0] t);
    int i;
    for (i = 0; i < fb.size(); i++) begin
      in_valid <= 1'b1;
      in_data <= fb[i];
      in_sop <= (i == 0);
      in_eop <= (i == fb.size() - 1);
      {push_byte_count, encap_table_index, qos_class, drop_precedence, classified_tc} <=
        {c, ix, q, d, t};
      @(posedge pclk);
      while (in_ready !== 1'b1) @(posedge pclk);
      in_valid <= 1'b0;
      in_data <= ~fb[i];
      // Idle cycle keeps one assignment per edge
      @(posedge pclk);
    end
  endtask
endmodule

// File: dv/mpetc_top_tb.sv
// Purpose: Self-checking bench for the push and remark block
// Assumes: One frame in flight at a time
// Notes: Random entries, q-map rows and sink stalls
`timescale 1ns/100ps
module mpetc_top_tb
  import mpetc_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_valid, in_ready, in_sop, in_eop, out_valid, out_sop, out_eop;
  logic out_ready = 1'b0, stall = 1'b0;
  logic [7:0] in_data, out_data;
  logic [5:0] push_byte_count;
  logic [3:0] encap_table_index;
  logic [2:0] qos_class, classified_tc;
  logic [1:0] drop_precedence;
  logic [31:0] qm [32];
  logic [9:0] got [$];
  int fail_count = 0, checked = 0, cyc = 0, frames = 0;
  mpetc_top u_mpetc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .push_byte_count(push_byte_count),
    .encap_table_index(encap_table_index), .qos_class(qos_class),
    .drop_precedence(drop_precedence), .classified_tc(classified_tc), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_sop(out_sop), .out_eop(out_eop));
  mpetc_src u_mpetc_src (.pclk(pclk), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_sop(in_sop), .in_eop(in_eop), .push_byte_count(push_byte_count),
    .encap_table_index(encap_table_index), .qos_class(qos_class),
    .drop_precedence(drop_precedence), .classified_tc(classified_tc));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    out_ready <= !stall && ($urandom_range(3) != 0);
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back({out_sop, out_eop, out_data});
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask
  task automatic chk_byte(input logic [9:0] g, input logic [9:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t out byte got %h exp %h", $time, g, x);
    end
  endtask
  // Holds every signal until pready is sampled, then one idle edge
  // A slave that never answers is caught by the run timeout, not here
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    logic [31:0] r, w [10];
    logic e;
    logic [319:0] ent;
    logic [271:0] pd;
    logic [7:0] fb [$];
    int ex [$];
    int t, i, n, cnt, ix, p0, p1, q, dp, ctc, len;
    void'($urandom(32'hA91E49AE));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    chk_word(r, 32'h1, "ctrl reset");
    for (i = 0; i < 32; i++) begin
      qm[i] = $urandom;
      apb(1'b1, QMAP_BASE + 12'(i * 4), qm[i], r, e);
    end
    for (t = 0; t < 14; t++) begin
      ix = $urandom_range(15, 1);
      for (i = 0; i < 10; i++) ent[i * 32 +: 32] = $urandom;
      // Entries follow wire order: the ethertype sits after the tag when there is one
      if (ent[294]) ent[143:128] = 16'h8847;
      else ent[175:160] = 16'h8847;
      for (i = 0; i < 10; i++) begin
        w[i] = ent[i * 32 +: 32];
        apb(1'b1, ENCAP_BASE + 12'(ix * 64 + i * 4), w[i], r, e);
      end
      apb(1'b0, ENCAP_BASE + 12'(ix * 64 + (t % 8) * 4), 32'h0, r, e);
      chk_word(r, w[t % 8], "entry readback");
      cnt = (t == 0) ? 0 : (t == 1) ? 34 : (t == 2) ? 47 : $urandom_range(34, 1);
      if (t == 3) ix = 0;
      if (t == 4) apb(1'b1, CTRL_ADDR, 32'h0, r, e);
      q = $urandom_range(7);
      dp = $urandom_range(3);
      ctc = $urandom_range(7);
      pd = ent[271:0];
      p0 = ent[294] ? 105 : 137;
      p1 = ent[294] ? 73 : 105;
      if (ent[275]) pd[p0 +: 3] = qm[{ent[274:272], 2'(dp)}][3 * q +: 3];
      else if (ent[272]) pd[p0 +: 3] = 3'(ctc);
      if (ent[279]) pd[p1 +: 3] = qm[{ent[278:276], 2'(dp)}][3 * q +: 3];
      else if (ent[276]) pd[p1 +: 3] = 3'(ctc);
      n = (cnt == 0 || ix == 0 || t == 4) ? 0 : (cnt > 34) ? 34 : cnt;
      frames += (n > 0);
      fb.delete();
      ex.delete();
      got.delete();
      for (i = 0; i < n; i++) ex.push_back((i == 0 ? 512 : 0) + pd[271 - 8 * i -: 8]);
      len = $urandom_range(6, 1);
      for (i = 0; i < len; i++) begin
        fb.push_back(8'($urandom));
        ex.push_back((n == 0 && i == 0 ? 512 : 0) + (i == len - 1 ? 256 : 0) + fb[i]);
      end
      // Long stall lets the FIFO fill and refuse before draining
      if (t % 4 == 1) fork
        begin
          stall <= 1'b1;
          repeat (60) @(posedge pclk);
          stall <= 1'b0;
        end
      join_none
      u_mpetc_src.send(fb, 6'(cnt), 4'(ix), 3'(q), 2'(dp), 3'(ctc));
      i = 0;
      while (got.size() < ex.size() && i < 400) begin
        @(posedge pclk);
        i++;
      end
      chk_word(got.size(), ex.size(), "byte total");
      for (i = 0; i < ex.size() && i < got.size(); i++) chk_byte(got[i], 10'(ex[i]));
      if (t == 4) apb(1'b1, CTRL_ADDR, 32'h1, r, e);
      $display("test %0d done, %0d pushed bytes", t, n);
    end
    apb(1'b0, FRAMES_ADDR, 32'h0, r, e);
    chk_word(r, frames, "pushed frames");
    apb(1'b0, 12'h48C, 32'h0, r, e);
    chk_word({r[30:0], e}, 32'h1, "unmapped read");
    results();
  end
endmodule
